// ---- rtl/audio_timer_pkg.sv ----
// constants, types and register map of the 10-bit audio timer
package audio_timer_pkg;

	// register byte addresses, one aligned word each
	localparam logic [11:0] ADDR_CTRL0 = 12'h000;
	localparam logic [11:0] ADDR_CTRL1 = 12'h004;
	localparam logic [11:0] ADDR_CNT_LO = 12'h008;
	localparam logic [11:0] ADDR_CNT_HI = 12'h00C;
	localparam logic [11:0] ADDR_A_LO = 12'h010;
	localparam logic [11:0] ADDR_A_HI = 12'h014;
	localparam logic [11:0] ADDR_B_LO = 12'h018;
	localparam logic [11:0] ADDR_B_HI = 12'h01C;
	localparam logic [11:0] ADDR_PERIOD = 12'h020;
	localparam logic [11:0] ADDR_FLAGS = 12'h024;

	// flag register bit positions, write one to clear
	localparam int FLAG_A_POS = 0;
	localparam int FLAG_P_POS = 1;
	localparam int FLAG_B_POS = 2;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [9:0] CMP_RESET = 10'h000;
	localparam logic [7:0] PERIOD_RESET = 8'h00;

	// prescale for the divided system tick
	localparam int TICK_DIV = 4;

	// counter tick source selection
	localparam logic [2:0] CLK_SEL_DIV4 = 3'h0;
	localparam logic [2:0] CLK_SEL_SYS = 3'h1;
	localparam logic [2:0] CLK_SEL_EXT_RISE = 3'h6;
	localparam logic [2:0] CLK_SEL_EXT_FALL = 3'h7;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_UNDEF = 2'b01,
		MODE_PWM = 2'b10,
		MODE_TIMER = 2'b11
	} mode_type;

	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_LOW = 2'b01,
		ACT_HIGH = 2'b10,
		ACT_TOGGLE = 2'b11
	} pin_action_type;

	// both control bytes as one carrier; the six stored ctrl0 bits fill the upper bits
	typedef struct packed {
		logic pause;
		logic [2:0] clk_sel;
		logic module_enable;
		logic pwm_submode_select;
		mode_type operating_mode_field;
		pin_action_type pin_action_field;
		logic output_initial_level;
		logic output_invert;
		logic period_duty_swap;
		logic counter_clear_select;
	} ctrl_type;

endpackage

// ---- rtl/audio_timer.sv ----
// 10-bit audio timer with compare, timer, normal pwm and audio pwm modes
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module audio_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_tick_pin,
	output logic timer_output_pin,
	output logic timer_output_pin_inverted,
	output logic audio_output_one,
	output logic audio_output_two,
	output logic pin_drive_enable
);
	import audio_timer_pkg::*;

	// register state
	ctrl_type ctrl_q;
	logic [9:0] a_buf_q;
	logic [9:0] b_buf_q;
	logic [7:0] p_buf_q;
	logic [9:0] a_act_q;
	logic [9:0] b_act_q;
	logic [7:0] p_act_q;
	logic flag_a_q, flag_p_q, flag_b_q;
	logic [9:0] cnt_q;
	logic enable_prev_q;
	logic cm_level_q;
	logic [1:0] div_q;
	logic ext_s1_q, ext_s2_q, ext_s3_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic pin_q;
	logic pin_n_q;
	logic audio_one_q;
	logic audio_two_q;
	logic drive_q;

	// combinational
	logic wr_en;
	logic setup;
	logic mapped;
	logic [7:0] rd_byte;
	logic tick_src;
	logic tick_en;
	logic enable_rise;
	logic [9:0] cnt_next;
	logic hit_a, hit_b, hit_p;
	logic is_pwm;
	logic is_audio;
	logic is_cm_like;
	logic swap_eff;
	logic period_hit;
	logic evt_a, evt_p, evt_b;
	logic [10:0] duty_one;
	logic pwm_one;
	logic pwm_two;
	logic [1:0] tick_last;

	// word write wins only with lane 0 enabled, data sits in the low byte
	function automatic logic wr_hit(input logic [11:0] addr, input logic [11:0] target);
		wr_hit = (addr == target);
	endfunction

	// pwm pin level from waveform state, pin action, active level and invert
	function automatic logic pwm_level(input logic wave, input pin_action_type act,
			input logic active_high, input logic invert);
		logic active;
		active = 1'b0;
		case (act)
			ACT_NONE: active = 1'b0;
			ACT_LOW: active = 1'b1;
			ACT_HIGH: active = wave;
			default: active = 1'b0;
		endcase
		pwm_level = (active ? active_high : ~active_high) ^ invert;
	endfunction

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready_q & pwrite & pstrb[0];
	assign tick_last = 2'(TICK_DIV - 1);

	// address decode and read mux
	always_comb begin
		mapped = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			ADDR_CTRL0: rd_byte = {ctrl_q.pause, ctrl_q.clk_sel, ctrl_q.module_enable,
				2'b00, ctrl_q.pwm_submode_select};
			ADDR_CTRL1: rd_byte = ctrl_q[7:0];
			ADDR_CNT_LO: rd_byte = cnt_q[7:0];
			ADDR_CNT_HI: rd_byte = {6'h00, cnt_q[9:8]};
			ADDR_A_LO: rd_byte = a_buf_q[7:0];
			ADDR_A_HI: rd_byte = {6'h00, a_buf_q[9:8]};
			ADDR_B_LO: rd_byte = b_buf_q[7:0];
			ADDR_B_HI: rd_byte = {6'h00, b_buf_q[9:8]};
			ADDR_PERIOD: rd_byte = p_buf_q;
			ADDR_FLAGS: rd_byte = {5'h00, flag_b_q, flag_p_q, flag_a_q};
			default: mapped = 1'b0;
		endcase
	end

	// apb answer: registered, so every access has exactly one access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			if (setup && !pwrite) begin
				prdata_q <= {24'h00_0000, rd_byte};
			end else if (setup) begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// control bytes; the swap bit is held at zero while audio is selected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= ctrl_type'({CTRL_RESET[5:0], CTRL_RESET});
		end else begin
			if (wr_en && wr_hit(paddr, ADDR_CTRL0)) begin
				ctrl_q.pause <= pwdata[7];
				ctrl_q.clk_sel <= pwdata[6:4];
				ctrl_q.module_enable <= pwdata[3];
				ctrl_q.pwm_submode_select <= pwdata[0];
			end
			if (wr_en && wr_hit(paddr, ADDR_CTRL1)) begin
				ctrl_q.operating_mode_field <= mode_type'(pwdata[7:6]);
				ctrl_q.pin_action_field <= pin_action_type'(pwdata[5:4]);
				ctrl_q.output_initial_level <= pwdata[3];
				ctrl_q.output_invert <= pwdata[2];
				ctrl_q.period_duty_swap <= pwdata[1] & ~ctrl_q.pwm_submode_select;
				ctrl_q.counter_clear_select <= pwdata[0];
			end else if (ctrl_q.pwm_submode_select) begin
				ctrl_q.period_duty_swap <= 1'b0;
			end
		end
	end

	// software-visible compare bytes, reset to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_buf_q <= CMP_RESET;
			b_buf_q <= CMP_RESET;
			p_buf_q <= PERIOD_RESET;
		end else if (wr_en) begin
			if (wr_hit(paddr, ADDR_A_LO)) a_buf_q[7:0] <= pwdata[7:0];
			if (wr_hit(paddr, ADDR_A_HI)) a_buf_q[9:8] <= pwdata[1:0];
			if (wr_hit(paddr, ADDR_B_LO)) b_buf_q[7:0] <= pwdata[7:0];
			if (wr_hit(paddr, ADDR_B_HI)) b_buf_q[9:8] <= pwdata[1:0];
			if (wr_hit(paddr, ADDR_PERIOD)) p_buf_q <= pwdata[7:0];
		end
	end

	// compare values in use: enabled audio mode reloads them only at period end,
	// so a half-written 10-bit pair never reaches the comparators mid-period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_act_q <= CMP_RESET;
			b_act_q <= CMP_RESET;
			p_act_q <= PERIOD_RESET;
		end else if (!is_audio || !ctrl_q.module_enable || evt_p) begin
			a_act_q <= a_buf_q;
			b_act_q <= b_buf_q;
			p_act_q <= p_buf_q;
		end
	end

	// mode decode
	assign is_pwm = (ctrl_q.operating_mode_field == MODE_PWM);
	assign is_audio = is_pwm & ctrl_q.pwm_submode_select;
	assign is_cm_like = (ctrl_q.operating_mode_field == MODE_COMPARE) ||
		(ctrl_q.operating_mode_field == MODE_TIMER);
	assign swap_eff = ctrl_q.period_duty_swap & ~ctrl_q.pwm_submode_select;

	// external tick pin: two flops before use, third only feeds edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_tick_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// free-running prescaler for the divided tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 2'b00;
		end else begin
			div_q <= (div_q == tick_last) ? 2'b00 : div_q + 2'b01;
		end
	end

	// tick source; unlisted selections fall back to the system clock
	always_comb begin
		case (ctrl_q.clk_sel)
			CLK_SEL_DIV4: tick_src = (div_q == tick_last);
			CLK_SEL_SYS: tick_src = 1'b1;
			CLK_SEL_EXT_RISE: tick_src = ext_s2_q & ~ext_s3_q;
			CLK_SEL_EXT_FALL: tick_src = ~ext_s2_q & ext_s3_q;
			default: tick_src = 1'b1;
		endcase
	end

	assign tick_en = ctrl_q.module_enable & ~ctrl_q.pause & tick_src;
	assign enable_rise = ctrl_q.module_enable & ~enable_prev_q;

	// comparators look at the value the counter is about to take
	assign cnt_next = cnt_q + 10'h001;
	assign hit_a = (cnt_next == a_act_q);
	assign hit_b = (cnt_next == b_act_q);
	// period zero matches on wrap to zero, giving 1024 counts
	assign hit_p = (cnt_next[9:2] == p_act_q) && (cnt_next[1:0] == 2'b00);

	// clearing source
	always_comb begin
		if (is_pwm) begin
			period_hit = swap_eff ? hit_a : hit_p;
		end else if (ctrl_q.counter_clear_select) begin
			period_hit = hit_a;
		end else begin
			period_hit = hit_p;
		end
	end

	// match events; a zero a value only marks overflow and raises nothing
	assign evt_a = tick_en & hit_a & (a_act_q != CMP_RESET) & (is_pwm | is_cm_like);
	assign evt_p = tick_en & hit_p & (is_pwm | (is_cm_like & ~ctrl_q.counter_clear_select));
	assign evt_b = tick_en & hit_b & (b_act_q != CMP_RESET) & is_audio;

	// counter: cleared by enable rising edge, holds while off or paused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= CMP_RESET;
			enable_prev_q <= 1'b0;
		end else begin
			enable_prev_q <= ctrl_q.module_enable;
			if (enable_rise) begin
				cnt_q <= CMP_RESET;
			end else if (tick_en) begin
				cnt_q <= period_hit ? CMP_RESET : cnt_next;
			end
		end
	end

	// sticky flags; a new match in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_a_q <= 1'b0;
			flag_p_q <= 1'b0;
			flag_b_q <= 1'b0;
		end else begin
			if (evt_a) begin
				flag_a_q <= 1'b1;
			end else if (wr_en && wr_hit(paddr, ADDR_FLAGS) && pwdata[FLAG_A_POS]) begin
				flag_a_q <= 1'b0;
			end
			if (evt_p) begin
				flag_p_q <= 1'b1;
			end else if (wr_en && wr_hit(paddr, ADDR_FLAGS) && pwdata[FLAG_P_POS]) begin
				flag_p_q <= 1'b0;
			end
			if (evt_b) begin
				flag_b_q <= 1'b1;
			end else if (wr_en && wr_hit(paddr, ADDR_FLAGS) && pwdata[FLAG_B_POS]) begin
				flag_b_q <= 1'b0;
			end
		end
	end

	// compare-mode pin level: loaded on the enable rise, then moved only by a-match events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cm_level_q <= 1'b0;
		end else if (enable_rise) begin
			cm_level_q <= ctrl_q.output_initial_level;
		end else if (evt_a && is_cm_like) begin
			case (ctrl_q.pin_action_field)
				ACT_NONE: cm_level_q <= cm_level_q;
				ACT_LOW: cm_level_q <= 1'b0;
				ACT_HIGH: cm_level_q <= 1'b1;
				ACT_TOGGLE: cm_level_q <= ~cm_level_q;
				default: cm_level_q <= cm_level_q;
			endcase
		end
	end

	// pwm waveforms: active while the count is below the duty value
	assign duty_one = swap_eff ? ((p_act_q == PERIOD_RESET) ? 11'h400 : {1'b0, p_act_q, 2'b00})
		: {1'b0, a_act_q};
	assign pwm_one = ({1'b0, cnt_q} < duty_one);
	assign pwm_two = (cnt_q < b_act_q);

	// output pins; idle levels are zero (one on the inverted pin) and timer or undefined mode frees the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= 1'b0;
			pin_n_q <= 1'b1;
			audio_one_q <= 1'b0;
			audio_two_q <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			drive_q <= (ctrl_q.operating_mode_field == MODE_COMPARE) || is_pwm;
			if (is_audio) begin
				pin_q <= 1'b0;
				pin_n_q <= 1'b1;
				audio_one_q <= pwm_level(pwm_one, ctrl_q.pin_action_field,
					ctrl_q.output_initial_level, ctrl_q.output_invert);
				audio_two_q <= pwm_level(pwm_two, ctrl_q.pin_action_field,
					ctrl_q.output_initial_level, ctrl_q.output_invert);
			end else if (is_pwm) begin
				pin_q <= pwm_level(pwm_one, ctrl_q.pin_action_field,
					ctrl_q.output_initial_level, ctrl_q.output_invert);
				pin_n_q <= ~pwm_level(pwm_one, ctrl_q.pin_action_field,
					ctrl_q.output_initial_level, ctrl_q.output_invert);
				audio_one_q <= 1'b0;
				audio_two_q <= 1'b0;
			end else begin
				pin_q <= cm_level_q ^ ctrl_q.output_invert;
				pin_n_q <= ~(cm_level_q ^ ctrl_q.output_invert);
				audio_one_q <= 1'b0;
				audio_two_q <= 1'b0;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign timer_output_pin = pin_q;
	assign timer_output_pin_inverted = pin_n_q;
	assign audio_output_one = audio_one_q;
	assign audio_output_two = audio_two_q;
	assign pin_drive_enable = drive_q;

	// checks
	a_swap_held_zero: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_q.pwm_submode_select |-> ##1
		(!ctrl_q.period_duty_swap || !ctrl_q.pwm_submode_select))
		else $error("swap bit survived audio selection");
	a_clear_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tick_en && !enable_rise && is_cm_like && ctrl_q.counter_clear_select && hit_a)
		|=> (cnt_q == 10'h000))
		else $error("counter not cleared on a match");
	a_clear_on_p: assert property (@(posedge pclk) disable iff (!presetn)
		(tick_en && !enable_rise && is_cm_like && !ctrl_q.counter_clear_select && hit_p)
		|=> (cnt_q == 10'h000) && flag_p_q)
		else $error("period match did not clear and flag");
	a_no_p_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(is_cm_like && ctrl_q.counter_clear_select && !flag_p_q) |=> !flag_p_q)
		else $error("p flag set with clear select high");
	a_overflow_no_a: assert property (@(posedge pclk) disable iff (!presetn)
		(a_act_q == 10'h000 && !flag_a_q) |=> !flag_a_q)
		else $error("a flag raised for zero compare value");
	a_period_multiple: assert property (@(posedge pclk) disable iff (!presetn)
		(tick_en && !enable_rise && is_cm_like && !ctrl_q.counter_clear_select
		&& cnt_q[1:0] != 2'b11) |=> (cnt_q == $past(cnt_q) + 10'h001))
		else $error("period match off a four-count boundary");
	a_pin_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		(evt_a && is_cm_like && !enable_rise
		&& ctrl_q.pin_action_field == ACT_TOGGLE) |=> (cm_level_q != $past(cm_level_q)))
		else $error("toggle action did not toggle");
	a_p_leaves_pin: assert property (@(posedge pclk) disable iff (!presetn)
		(!evt_a && !enable_rise) |=> $stable(cm_level_q))
		else $error("pin moved without an a match");
	a_enable_init: assert property (@(posedge pclk) disable iff (!presetn)
		enable_rise |=> (cm_level_q == $past(ctrl_q.output_initial_level)) && (cnt_q == 10'h000))
		else $error("enable edge did not load initial state");
	a_timer_freed: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_q.operating_mode_field == MODE_TIMER) |=> !pin_drive_enable)
		else $error("pin driven in timer mode");
	a_audio_shadow: assert property (@(posedge pclk) disable iff (!presetn)
		(is_audio && ctrl_q.module_enable && !evt_p) |=> $stable(a_act_q) && $stable(p_act_q))
		else $error("audio compare value changed mid-period");
	a_counter_high: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && paddr == ADDR_CNT_HI) |=> (prdata[31:2] == 30'h0000_0000))
		else $error("counter high byte upper bits not zero");

endmodule

// ---- sim/speaker_stage.sv ----
// receiving stage model: measures period and high time of one pwm line
`timescale 1ns/1ps
module speaker_stage (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wave,
	output logic [15:0] rises,
	output logic [15:0] last_period,
	output logic [15:0] last_high
);
	logic prev_q;
	logic [15:0] cnt_q;
	logic [15:0] high_q;

	// edge timing in pclk cycles; a speaker only listens and never loads the line back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
			cnt_q <= 16'h0000;
			high_q <= 16'h0000;
			rises <= 16'h0000;
			last_period <= 16'h0000;
			last_high <= 16'h0000;
		end else begin
			prev_q <= wave;
			if (wave && !prev_q) begin
				rises <= rises + 16'h0001;
				last_period <= cnt_q;
				cnt_q <= 16'h0001;
				high_q <= 16'h0001;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
				if (wave) begin
					high_q <= high_q + 16'h0001;
				end
				// high time is only known once the line falls
				if (!wave && prev_q) begin
					last_high <= high_q;
				end
			end
		end
	end
endmodule

// ---- sim/audio_timer_tb_top.sv ----
// self-checking bench for the 10-bit audio timer
`timescale 1ns/1ps
module audio_timer_tb_top;
	import audio_timer_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_tick_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic timer_output_pin, timer_output_pin_inverted, audio_output_one, audio_output_two;
	logic pin_drive_enable, wave;
	logic [1:0] probe_sel;
	logic [15:0] rises, last_period, last_high;
	int fail_count, checks, cycles;
	logic [11:0] reg_list [9] = '{ADDR_CNT_LO, ADDR_CNT_HI, ADDR_A_LO, ADDR_A_HI, ADDR_B_LO,
		ADDR_B_HI, ADDR_PERIOD, ADDR_CTRL0, ADDR_CTRL1};

	audio_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_tick_pin(ext_tick_pin),
		.timer_output_pin(timer_output_pin),
		.timer_output_pin_inverted(timer_output_pin_inverted),
		.audio_output_one(audio_output_one), .audio_output_two(audio_output_two),
		.pin_drive_enable(pin_drive_enable));

	// one listener, switched between the three output lines
	assign wave = (probe_sel == 2'h0) ? timer_output_pin :
		((probe_sel == 2'h1) ? audio_output_one : audio_output_two);
	speaker_stage listener (.pclk(pclk), .presetn(presetn), .wave(wave), .rises(rises),
		.last_period(last_period), .last_high(last_high));

	always #5 pclk = ~pclk;

	// hang guard, well above the longest sequence
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	// apb transfer; entered just after a rising edge, leaves just after one
	// answer taken at the rising edge that sees pready; one idle edge follows the release
	task automatic apb(input logic is_wr, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n == 50) begin
			fail_count++;
		end
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rdchk(input string what, input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] q;
		logic e;
		apb(1'b0, a, 8'h00, q, e);
		chk(what, {24'h00_0000, exp}, {24'h00_0000, q});
	endtask

	task automatic wait_rises(input int n);
		logic [15:0] start;
		int k;
		start = rises;
		k = 0;
		while (16'(rises - start) < n[15:0] && k < 9000) begin
			@(posedge pclk);
			k++;
		end
		if (k == 9000) begin
			fail_count++;
		end
	endtask

	task automatic measure(input logic [1:0] sel, input int per, input int hi);
		probe_sel <= sel;
		wait_rises(3);
		chk("period", per, {16'h0000, last_period});
		chk("high time", hi, {16'h0000, last_high});
	endtask

	// stop, clear flags, configure, load compares, then start with a clean enable rise
	task automatic run(input logic [7:0] c1, input logic sub, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] p);
		wr(ADDR_CTRL0, {1'b0, CLK_SEL_SYS, 1'b0, 2'b00, sub});
		wr(ADDR_FLAGS, 8'h07);
		wr(ADDR_CTRL1, c1);
		wr(ADDR_A_LO, a);
		wr(ADDR_B_LO, b);
		wr(ADDR_PERIOD, p);
		wr(ADDR_CTRL0, {1'b0, CLK_SEL_SYS, 1'b1, 2'b00, sub});
	endtask

	task automatic t_regs();
		logic [7:0] q;
		logic e;
		for (int i = 0; i < 9; i++) begin
			rdchk("reset value", reg_list[i], 8'h00);
		end
		wr(ADDR_A_HI, 8'hFF);
		rdchk("compare a high", ADDR_A_HI, 8'h03);
		wr(ADDR_B_LO, 8'hA5);
		rdchk("compare b low", ADDR_B_LO, 8'hA5);
		pstrb <= 4'hE;
		wr(ADDR_A_LO, 8'h77);
		pstrb <= 4'hF;
		rdchk("strobe off write", ADDR_A_LO, 8'h00);
		wr(ADDR_CNT_LO, 8'h55);
		rdchk("counter low", ADDR_CNT_LO, 8'h00);
		apb(1'b0, 12'h03C, 8'h00, q, e);
		chk("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
		wr(ADDR_A_HI, 8'h00);
	endtask

	task automatic t_compare();
		logic [7:0] c1;
		logic exp;
		run(8'h38, 1'b0, 8'h03, 8'h00, 8'h02);
		measure(2'h0, 16, 8);
		rdchk("flags clear on p", ADDR_FLAGS, 8'h03);
		chk("drive enable", 32'h0000_0001, {31'h0000_0000, pin_drive_enable});
		chk("complement", {31'h0000_0000, ~timer_output_pin},
			{31'h0000_0000, timer_output_pin_inverted});
		// none, low, high: each starts from the opposite initial level where it matters
		for (int i = 0; i < 3; i++) begin
			c1 = {2'b00, i[1:0], (i == 2) ? 1'b0 : 1'b1, 3'b000};
			exp = (i == 1) ? 1'b0 : 1'b1;
			run(c1, 1'b0, 8'h03, 8'h00, 8'h02);
			repeat (40) @(posedge pclk);
			chk("pin action", {31'h0000_0000, exp}, {31'h0000_0000, timer_output_pin});
		end
		run(8'hF0, 1'b0, 8'h03, 8'h00, 8'h02);
		repeat (40) @(posedge pclk);
		rdchk("timer mode flags", ADDR_FLAGS, 8'h03);
		chk("timer drive", 32'h0000_0000, {31'h0000_0000, pin_drive_enable});
	endtask

	task automatic t_clear_a();
		// p below a, yet only the a match may act
		run(8'h39, 1'b0, 8'h05, 8'h00, 8'h01);
		measure(2'h0, 10, 5);
		rdchk("flags clear on a", ADDR_FLAGS, 8'h01);
		run(8'h31, 1'b0, 8'h00, 8'h00, 8'h00);
		repeat (1100) @(posedge pclk);
		rdchk("overflow flags", ADDR_FLAGS, 8'h00);
		chk("overflow pin", 32'h0000_0000, {31'h0000_0000, timer_output_pin});
		run(8'h30, 1'b0, 8'h01, 8'h00, 8'h00);
		measure(2'h0, 2048, 1024);
		rdchk("wrap flags", ADDR_FLAGS, 8'h03);
	endtask

	task automatic t_pwm();
		logic [7:0] q;
		logic e;
		// clear select set on purpose: pwm must ignore it; duty kept below period
		run(8'hA9, 1'b0, 8'h04, 8'h00, 8'h04);
		measure(2'h0, 16, 4);
		chk("audio idle", 32'h0000_0000, {31'h0000_0000, audio_output_one});
		run(8'hAB, 1'b0, 8'h0C, 8'h00, 8'h01);
		measure(2'h0, 12, 4);
		// divided tick stretches every count to four system clocks
		wr(ADDR_CTRL0, {1'b0, CLK_SEL_DIV4, 1'b1, 2'b00, 1'b0});
		measure(2'h0, 48, 16);
		// pause must freeze the count
		wr(ADDR_CTRL0, {1'b1, CLK_SEL_DIV4, 1'b1, 2'b00, 1'b0});
		apb(1'b0, ADDR_CNT_LO, 8'h00, q, e);
		repeat (20) @(posedge pclk);
		rdchk("paused count", ADDR_CNT_LO, q);
	endtask

	task automatic t_audio();
		run(8'hAA, 1'b1, 8'h08, 8'h04, 8'h04);
		rdchk("swap forced", ADDR_CTRL1, 8'hA8);
		measure(2'h1, 16, 8);
		measure(2'h2, 16, 4);
		rdchk("audio flags", ADDR_FLAGS, 8'h07);
		chk("pin in audio", 32'h0000_0000, {31'h0000_0000, timer_output_pin});
		// new duty written early in a high phase must wait for the period end
		probe_sel <= 2'h1;
		wait_rises(2);
		wr(ADDR_A_LO, 8'h0C);
		wait_rises(1);
		chk("shadow old duty", 8, {16'h0000, last_high});
		wait_rises(1);
		chk("shadow new duty", 12, {16'h0000, last_high});
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		ext_tick_pin = 1'b0;
		probe_sel = 2'h0;
		fail_count = 0;
		checks = 0;
		cycles = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_compare();
		t_clear_a();
		t_pwm();
		t_audio();
		tally_and_finish();
	end
endmodule
